// ---- rtl/rtd_defines.svh ----
`ifndef RTD_DEFINES_SVH
`define RTD_DEFINES_SVH

// register map
`define RTD_REG_CTRL 8'h00
`define RTD_REG_CFG 8'h04
`define RTD_REG_STAT 8'h08
`define RTD_REG_MASK 8'h0c
`define RTD_REG_TIME 8'h10
`define RTD_CTRL_START 0
`define RTD_CTRL_STOP 1
`define RTD_CFG_SEL_LO 0
`define RTD_CFG_TZ_LO 8
`define RTD_STAT_DONE 0
`define RTD_STAT_ERR 1
`define RTD_STAT_REJ 2
// timing
`define RTD_CLK_NS 50
`define RTD_MS_NS 1000000
`define RTD_BIT1_MS 12'h096
`define RTD_MARK_MS 12'h5dc
`define RTD_DISP_MS 10'h3e8
`define RTD_TIMEOUT_MIN 30
`define RTD_MS_PER_MIN 60000
`define RTD_MIN_PER_TZ 30
// frame layout
`define RTD_FRAME_BITS 6'h3b
`define RTD_NO_SYNC 6'h3f
`define RTD_MIN_LO 21
`define RTD_MIN_P 28
`define RTD_HOUR_LO 29
`define RTD_HOUR_P 35
`define RTD_DAY_LO 36
`define RTD_MON_LO 45
`define RTD_YEAR_LO 50
`define RTD_DATE_P 58
`define RTD_AUTO_HOUR 5'h01
`define RTD_YEAR_BASE 8'h0a
`endif

// ---- rtl/rtd_pkg.sv ----
package rtd_pkg;
    typedef enum logic {RTD_IDLE, RTD_RUN} rtd_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } rtd_bus_t;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic error;
    } rtd_rtc_t;

    typedef struct packed {
        rtd_state_t state;
        logic [15:0] tickCnt;
        logic antPrev;
        logic [11:0] lowMs;
        logic [11:0] highMs;
        logic [5:0] bitIdx;
        logic [58:0] frame;
        logic [31:0] prevMin;
        logic havePrev;
        logic [23:0] toMs;
        logic [9:0] dispMs;
        logic disp;
        logic active;
        logic done;
        logic err;
        logic rtcLoad;
        logic [31:0] loadMin;
        logic rtcErrPrev;
        logic autoPrev;
        logic [2:0] sel;
        logic [7:0] tz;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [31:0] rdata;
        logic irq;
    } rtd_regs_t;
endpackage

// ---- rtl/rtd_radio_time_decoder.sv ----
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rtd_defines.svh"
module rtd_radio_time_decoder #(
    parameter int TICK_CYCLES = `RTD_MS_NS / `RTD_CLK_NS,
    parameter int TIMEOUT_MS = `RTD_TIMEOUT_MIN * `RTD_MS_PER_MIN
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input rtd_pkg::rtd_bus_t bus,
    output logic [31:0] rdata,
    // antenna comparator levels, low during a dip
    input wire logic [7:0] antIn,
    // real time clock
    input rtd_pkg::rtd_rtc_t rtc,
    output logic rtcLoad,
    output logic [31:0] rtcLoadMinutes,
    // flags
    output logic decodeActiveFlag,
    output logic decodeDonePulse,
    output logic decodeErrorFlag,
    output logic noSignalShown,
    output logic irq
);
    import rtd_pkg::*;

    rtd_regs_t q;
    rtd_regs_t d;

    function automatic logic [7:0] bcd(input logic [7:0] v);
        bcd = 8'(v[7:4]) * 8'h0a + 8'(v[3:0]);
    endfunction

    function automatic logic [8:0] monthStart(input logic [7:0] mo);
        case (mo)
            8'h02: monthStart = 9'h01f;
            8'h03: monthStart = 9'h03b;
            8'h04: monthStart = 9'h05a;
            8'h05: monthStart = 9'h078;
            8'h06: monthStart = 9'h097;
            8'h07: monthStart = 9'h0b5;
            8'h08: monthStart = 9'h0d4;
            8'h09: monthStart = 9'h0f3;
            8'h0a: monthStart = 9'h111;
            8'h0b: monthStart = 9'h130;
            8'h0c: monthStart = 9'h14e;
            default: monthStart = 9'h000;
        endcase
    endfunction

    // minutes since the start of 1990
    function automatic logic [31:0] epochMin(input logic [7:0] yy, input logic [7:0] mo,
            input logic [7:0] dd, input logic [7:0] hh, input logic [7:0] mm);
        logic [7:0] y;
        logic [31:0] days;
        y = yy + `RTD_YEAR_BASE;
        days = 32'(y) * 32'h16d + 32'((y + 8'h01) >> 2) + 32'(monthStart(mo)) + 32'(dd) - 32'h1;
        if (yy[1:0] == 2'b00 && mo > 8'h02) begin
            days = days + 32'h1;
        end
        epochMin = (days * 32'h18 + 32'(hh)) * 32'h3c + 32'(mm);
    endfunction

    logic ant;
    logic [7:0] fMin;
    logic [7:0] fHour;
    logic [7:0] fDay;
    logic [7:0] fMon;
    logic [7:0] fYear;
    logic parityOk;
    logic rangeOk;
    logic frameOk;
    logic [31:0] curMin;
    logic tick;
    logic fall;
    logic rise;
    logic startReq;
    logic stopReq;
    logic autoHit;

    assign ant = antIn[q.sel];
    assign fMin = bcd({1'b0, q.frame[`RTD_MIN_P-1:`RTD_MIN_LO]});
    assign fHour = bcd({2'b00, q.frame[`RTD_HOUR_P-1:`RTD_HOUR_LO]});
    assign fDay = bcd({2'b00, q.frame[`RTD_DAY_LO+5:`RTD_DAY_LO]});
    assign fMon = bcd({3'b000, q.frame[`RTD_MON_LO+4:`RTD_MON_LO]});
    assign fYear = bcd(q.frame[`RTD_DATE_P-1:`RTD_YEAR_LO]);
    // even parity over each field together with its parity bit
    assign parityOk = ~^q.frame[`RTD_MIN_P:`RTD_MIN_LO]
        && ~^q.frame[`RTD_HOUR_P:`RTD_HOUR_LO]
        && ~^q.frame[`RTD_DATE_P:`RTD_DAY_LO];
    assign rangeOk = fMin <= 8'h3b && fHour <= 8'h17 && fDay >= 8'h01 && fDay <= 8'h1f
        && fMon >= 8'h01 && fMon <= 8'h0c && fYear <= 8'h3b;
    assign frameOk = parityOk && rangeOk && q.bitIdx == `RTD_FRAME_BITS;
    assign curMin = epochMin(fYear, fMon, fDay, fHour, fMin);
    assign tick = q.tickCnt == 16'(TICK_CYCLES - 1);
    assign fall = q.antPrev && !ant;
    assign rise = !q.antPrev && ant;
    assign autoHit = rtc.hour == `RTD_AUTO_HOUR && rtc.minute == 6'h00;
    assign startReq = bus.we && bus.addr == `RTD_REG_CTRL && bus.wdata[`RTD_CTRL_START];
    assign stopReq = bus.we && bus.addr == `RTD_REG_CTRL && bus.wdata[`RTD_CTRL_STOP];

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rtcLoad = 1'b0;
        d.rdata = 32'h0;
        d.tickCnt = tick ? 16'h0 : q.tickCnt + 16'h1;
        d.antPrev = ant;
        d.rtcErrPrev = rtc.error;
        d.autoPrev = autoHit;

        // register port; status clears on read, sets below win
        if (bus.re) begin
            case (bus.addr)
                `RTD_REG_CTRL: d.rdata = {29'h0, q.err, q.disp, q.active};
                `RTD_REG_CFG: d.rdata = {16'h0, q.tz, 5'h0, q.sel};
                `RTD_REG_STAT: begin
                    d.rdata = {29'h0, q.stat};
                    d.stat = 3'h0;
                end
                `RTD_REG_MASK: d.rdata = {29'h0, q.mask};
                `RTD_REG_TIME: d.rdata = q.loadMin;
                default: d.rdata = 32'h0;
            endcase
        end
        if (bus.we) begin
            case (bus.addr)
                `RTD_REG_CFG: begin
                    d.sel = bus.wdata[`RTD_CFG_SEL_LO+2:`RTD_CFG_SEL_LO];
                    d.tz = bus.wdata[`RTD_CFG_TZ_LO+7:`RTD_CFG_TZ_LO];
                end
                `RTD_REG_MASK: d.mask = bus.wdata[2:0];
                default: ;
            endcase
        end

        case (q.state)
            RTD_IDLE: begin
                d.disp = 1'b0;
                if (startReq || (autoHit && !q.autoPrev)
                        || (rtc.error && !q.rtcErrPrev)) begin
                    d.state = RTD_RUN;
                    d.active = 1'b1;
                    d.err = 1'b0;
                    d.toMs = 24'h0;
                    d.dispMs = 10'h0;
                    d.havePrev = 1'b0;
                    d.bitIdx = `RTD_NO_SYNC;
                    d.lowMs = 12'h0;
                    d.highMs = 12'h0;
                end
            end
            RTD_RUN: begin
                if (tick) begin
                    d.toMs = q.toMs + 24'h1;
                    if (!ant && q.lowMs != 12'hfff) begin
                        d.lowMs = q.lowMs + 12'h1;
                    end
                    if (ant && q.highMs != 12'hfff) begin
                        d.highMs = q.highMs + 12'h1;
                    end
                    if (q.dispMs == `RTD_DISP_MS - 10'h1) begin
                        d.dispMs = 10'h0;
                        d.disp = !q.disp;
                    end else begin
                        d.dispMs = q.dispMs + 10'h1;
                    end
                end
                if (rise) begin
                    if (q.bitIdx < `RTD_FRAME_BITS) begin
                        d.frame[q.bitIdx] = q.lowMs >= `RTD_BIT1_MS;
                        d.bitIdx = q.bitIdx + 6'h1;
                    end
                    d.highMs = 12'h0;
                end
                if (fall) begin
                    d.lowMs = 12'h0;
                    if (q.highMs >= `RTD_MARK_MS) begin
                        d.bitIdx = 6'h0;
                        if (frameOk) begin
                            if (q.havePrev && curMin == q.prevMin + 32'h1) begin
                                d.rtcLoad = 1'b1;
                                d.loadMin = curMin
                                    + 32'($signed(q.tz) * `RTD_MIN_PER_TZ);
                                d.state = RTD_IDLE;
                                d.active = 1'b0;
                                d.done = 1'b1;
                                d.stat[`RTD_STAT_DONE] = 1'b1;
                            end else begin
                                d.prevMin = curMin;
                                d.havePrev = 1'b1;
                            end
                        end else begin
                            d.havePrev = 1'b0;
                            if (q.bitIdx != `RTD_NO_SYNC) begin
                                d.stat[`RTD_STAT_REJ] = 1'b1;
                            end
                        end
                    end
                end
                if (tick && q.toMs >= 24'(TIMEOUT_MS - 1) && !d.done) begin
                    d.state = RTD_IDLE;
                    d.active = 1'b0;
                    d.err = 1'b1;
                    d.stat[`RTD_STAT_ERR] = 1'b1;
                end
                if (stopReq && !d.done) begin
                    d.state = RTD_IDLE;
                    d.active = 1'b0;
                end
            end
            default: d.state = RTD_IDLE;
        endcase
        d.irq = |(d.stat & d.mask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.state <= RTD_IDLE;
            q.antPrev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign rtcLoad = q.rtcLoad;
    assign rtcLoadMinutes = q.loadMin;
    assign decodeActiveFlag = q.active;
    assign decodeDonePulse = q.done;
    assign decodeErrorFlag = q.err;
    assign noSignalShown = q.disp;
    assign irq = q.irq;

    a_done_one_pulse: assert property (@(posedge clk) disable iff (reset)
        q.done |=> !q.done) else $error("done pulse longer than one cycle");
    a_done_ends_phase: assert property (@(posedge clk) disable iff (reset)
        $rose(q.done) |-> q.rtcLoad && !q.active && $past(q.active))
        else $error("done without load or phase end");
    a_load_step_one: assert property (@(posedge clk) disable iff (reset)
        q.rtcLoad |-> $past(q.havePrev) && $past(curMin) == $past(q.prevMin) + 32'h1)
        else $error("load without a one-minute step");
    a_error_ends_phase: assert property (@(posedge clk) disable iff (reset)
        $rose(q.err) |-> !q.active && q.stat[`RTD_STAT_ERR])
        else $error("error flag while still active");
    a_timeout_bound: assert property (@(posedge clk) disable iff (reset)
        q.active |-> q.toMs < 24'(TIMEOUT_MS)) else $error("timeout exceeded");
    a_manual_start: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_IDLE && startReq |=> q.active && !q.err)
        else $error("manual start ignored");
    a_bad_parity: assert property (@(posedge clk) disable iff (reset)
        q.active && fall && q.highMs >= `RTD_MARK_MS && !parityOk |=> !q.rtcLoad && !q.havePrev)
        else $error("frame with bad parity kept");
    a_idle_display: assert property (@(posedge clk) disable iff (reset)
        !q.active ##1 !q.active |-> !q.disp) else $error("indication toggles while idle");
    a_irq_source: assert property (@(posedge clk) disable iff (reset)
        $rose(q.irq) |-> |(q.stat & q.mask)) else $error("interrupt without status");
    a_stat_read_clear: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_IDLE && bus.re && bus.addr == `RTD_REG_STAT |=> q.stat == 3'h0 && !q.irq)
        else $error("status not cleared by read");
    // phase start and stop, and the no-signal indication
    a_start_fresh: assert property (@(posedge clk) disable iff (reset)
        $rose(q.active) |-> !q.err && q.toMs == 24'h0 && !q.havePrev && q.bitIdx == `RTD_NO_SYNC)
        else $error("phase started with stale state");
    a_auto_start: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_IDLE && autoHit && !q.autoPrev |=> q.active)
        else $error("one o'clock start missed");
    a_error_start: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_IDLE && rtc.error && !q.rtcErrPrev |=> q.active)
        else $error("clock error start missed");
    a_stop_request: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && stopReq |=> !q.active)
        else $error("manual stop ignored");
    a_timeout_ends: assert property (@(posedge clk) disable iff (reset)
        q.active && tick && q.toMs >= 24'(TIMEOUT_MS - 1) |=> !q.active && (q.err || q.done))
        else $error("phase outlived its timeout");
    a_disp_toggle: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && tick && q.dispMs == `RTD_DISP_MS - 10'h1 |=> q.disp != $past(q.disp))
        else $error("indication did not alternate");
    // bit and frame handling
    a_bit_advance: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && rise && q.bitIdx < `RTD_FRAME_BITS |=> q.bitIdx == $past(q.bitIdx) + 6'h1)
        else $error("bit not stored");
    a_marker_resync: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && fall && q.highMs >= `RTD_MARK_MS |=> q.bitIdx == 6'h0)
        else $error("minute marker not taken");
    a_unsynced_ignored: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && rise && q.bitIdx == `RTD_NO_SYNC |=> q.bitIdx == `RTD_NO_SYNC)
        else $error("bit stored before first marker");
    a_range_reject: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && fall && q.highMs >= `RTD_MARK_MS && !rangeOk
        |=> !q.rtcLoad && !q.havePrev) else $error("out of range frame kept");
    a_short_frame: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && fall && q.highMs >= `RTD_MARK_MS && q.bitIdx != `RTD_FRAME_BITS
        |=> !q.rtcLoad && !q.havePrev) else $error("incomplete frame kept");
    a_reject_flag: assert property (@(posedge clk) disable iff (reset)
        q.state == RTD_RUN && fall && q.highMs >= `RTD_MARK_MS && !frameOk
        && q.bitIdx != `RTD_NO_SYNC |=> q.stat[`RTD_STAT_REJ]) else $error("reject not flagged");
    a_load_with_done: assert property (@(posedge clk) disable iff (reset)
        q.rtcLoad |-> q.done && !q.active)
        else $error("clock loaded without completion");
    a_done_status: assert property (@(posedge clk) disable iff (reset)
        q.done |-> q.stat[`RTD_STAT_DONE] && !q.err)
        else $error("completion without done status");
endmodule

// ---- testbench/rtd_antenna_model.sv ----
`timescale 1ns/1ps
module rtd_antenna_model #(
    parameter int TICK_CYCLES = 1
) (
    // clock and selected input
    input wire logic clk,
    input wire logic [2:0] chan,
    // comparator levels, low during a dip
    output wire logic [7:0] antIn
);
    logic line = 1'b1;
    // unselected inputs carry the inverted code, so a wrong select garbles
    assign antIn = {8{~line}} ^ (8'h01 << chan);
    task automatic hold(input logic lvl, input int ms);
        line <= lvl;
        repeat (ms * TICK_CYCLES) @(posedge clk);
    endtask
    // one dip then a long carrier gap marks the minute
    task automatic sync();
        hold(1'b0, 100);
        hold(1'b1, 1600);
    endtask
    task automatic frame(input logic [58:0] f);
        for (int i = 0; i < 59; i++) begin
            hold(1'b0, f[i] ? 200 : 100);
            hold(1'b1, i == 58 ? 1600 : 5);
        end
    endtask
    // first dip of the next minute, which closes the frame before it
    task automatic dip();
        hold(1'b0, 100);
        hold(1'b1, 5);
    endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "rtd_defines.svh"
module tb;
    import rtd_pkg::*;
    localparam int TMO = 42000;
    localparam logic [31:0] EXP = 32'(3652 * 1440 + 12 * 60 + 32 - 90);
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } rtd_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    rtd_bus_t bus = '0;
    rtd_rtc_t rtc = '{hour: 5'h00, minute: 6'h05, error: 1'b0};
    logic [2:0] chan = 3'h0;
    logic [7:0] antIn;
    logic [31:0] rdata, rtcLoadMinutes, lastLoad, got;
    logic rtcLoad, decodeActiveFlag, decodeDonePulse, decodeErrorFlag, noSignalShown, irq;
    logic doneAtLoad, ns;
    int err_count = 0, compares = 0, loads = 0, doneCnt = 0, cyc = 0, t0, n;
    rtd_row_t rows [6];
    always #25 clk = ~clk;
    rtd_radio_time_decoder #(.TICK_CYCLES(1), .TIMEOUT_MS(TMO)) uut (
        .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .antIn(antIn), .rtc(rtc),
        .rtcLoad(rtcLoad), .rtcLoadMinutes(rtcLoadMinutes),
        .decodeActiveFlag(decodeActiveFlag), .decodeDonePulse(decodeDonePulse),
        .decodeErrorFlag(decodeErrorFlag), .noSignalShown(noSignalShown), .irq(irq));
    rtd_antenna_model #(.TICK_CYCLES(1)) ant (.clk(clk), .chan(chan), .antIn(antIn));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rtcLoad === 1'b1) begin
            loads <= loads + 1;
            lastLoad <= rtcLoadMinutes;
            doneAtLoad <= decodeDonePulse;
        end
        if (decodeDonePulse === 1'b1) doneCnt <= doneCnt + 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // frame dated 2000-01-01, a saturday
    function automatic logic [58:0] frm(input logic [6:0] mi, input logic [5:0] hr,
            input logic flip);
        logic [58:0] f;
        f = '0;
        f[20] = 1'b1;
        f[27:21] = mi;
        f[28] = ^mi ^ flip;
        f[34:29] = hr;
        f[35] = ^hr;
        f[36] = 1'b1;
        f[44:42] = 3'h6;
        f[45] = 1'b1;
        f[58] = ^f[57:36];
        return f;
    endfunction
    // about two fifths again the span the sequence needs
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial begin
        rows[0] = '{`RTD_REG_CFG, 32'hffff_ffff, 32'h0000_ff07};
        rows[1] = '{`RTD_REG_CFG, 32'h0000_fd05, 32'h0000_fd05};
        rows[2] = '{`RTD_REG_MASK, 32'hffff_ffff, 32'h0000_0007};
        rows[3] = '{`RTD_REG_CTRL, 32'h0000_0000, 32'h0000_0000};
        rows[4] = '{`RTD_REG_TIME, 32'h1234_5678, 32'h0000_0000};
        rows[5] = '{8'h14, 32'hffff_ffff, 32'h0000_0000};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({decodeActiveFlag, rtcLoad, decodeDonePulse, decodeErrorFlag, irq}), 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            chk(got, rows[i].e);
        end
        rtc <= '{hour: 5'h01, minute: 6'h00, error: 1'b0};
        repeat (3) @(posedge clk);
        chk(32'(decodeActiveFlag), 32'h1);
        n = 0;
        ns = noSignalShown;
        repeat (2500) begin
            @(posedge clk);
            if (noSignalShown !== ns) n++;
            ns = noSignalShown;
        end
        chk(32'(n), 32'h2);
        rd(`RTD_REG_CTRL, got);
        chk(32'(got[0]), 32'h1);
        wr(`RTD_REG_CTRL, 32'h2);
        @(posedge clk);
        chk(32'({decodeActiveFlag, decodeErrorFlag, noSignalShown}), 32'h0);
        rtc <= '{hour: 5'h00, minute: 6'h05, error: 1'b1};
        repeat (3) @(posedge clk);
        chk(32'(decodeActiveFlag), 32'h1);
        wr(`RTD_REG_CTRL, 32'h2);
        rd(`RTD_REG_STAT, got);
        chk(got, 32'h0);
        // bad parity, good, two-minute step, out-of-range minute: nothing may load
        chan <= 3'h2;
        wr(`RTD_REG_CFG, 32'h0000_0002);
        wr(`RTD_REG_CTRL, 32'h1);
        t0 = cyc;
        ant.sync();
        ant.frame(frm(7'h07, 6'h12, 1'b1));
        ant.frame(frm(7'h08, 6'h12, 1'b0));
        ant.frame(frm(7'h10, 6'h12, 1'b0));
        ant.frame(frm(7'h71, 6'h11, 1'b0));
        ant.dip();
        n = 0;
        while (decodeActiveFlag !== 1'b0 && n < TMO) begin
            @(posedge clk);
            n++;
        end
        chk(32'(cyc - t0 >= TMO - 4 && cyc - t0 <= TMO + 8), 32'h1);
        chk(32'(loads + doneCnt), 32'h0);
        chk(32'({decodeErrorFlag, irq}), 32'h3);
        rd(`RTD_REG_STAT, got);
        chk(got, 32'h6);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        chan <= 3'h5;
        wr(`RTD_REG_CFG, 32'h0000_fd05);
        wr(`RTD_REG_CTRL, 32'h1);
        chk(32'({decodeActiveFlag, decodeErrorFlag}), 32'h2);
        ant.sync();
        ant.frame(frm(7'h31, 6'h12, 1'b0));
        ant.frame(frm(7'h32, 6'h12, 1'b0));
        ant.dip();
        chk(32'(loads), 32'h1);
        chk(lastLoad, EXP);
        chk(32'({doneAtLoad, decodeActiveFlag, decodeDonePulse}), 32'h4);
        chk(32'(doneCnt), 32'h1);
        rd(`RTD_REG_STAT, got);
        chk(got & 32'h3, 32'h1);
        rd(`RTD_REG_TIME, got);
        chk(got, EXP);
        // reset in mid-phase with the clock error still high restarts decoding
        wr(`RTD_REG_CTRL, 32'h1);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({decodeActiveFlag, rtcLoad, decodeDonePulse, decodeErrorFlag, noSignalShown, irq}), 32'h0);
        rd(`RTD_REG_CFG, got);
        chk(got, 32'h0);
        chk(32'(decodeActiveFlag), 32'h1);
        stop_test();
    end
endmodule
